//--- hdl/vid_fmt4_map.vh
// constants of the format 4 video packet body formatter
// Summary of operation
// - a packet holds equal segments of one frame, one frame, or several whole frames
// - packet body opens with the channel-specific word, frame data or per-frame header follows at once
// - bits 31-30 give segment position: 00 middle, 01 first, 10 last
// - bits 29-28 give content: 00 segment, 01 one frame, 10 several frames
// - bit 27 set when a per-frame header precedes each frame or first segment
// - bits 26-0 of the channel-specific word carry no information
// - per-frame header is twelve bytes: time low, time high, frame length
// - relative time is the 48-bit counter at the first data bit, upper bits zero
// - with absolute time selected, header holds absolute time in the selected format
// - header time is the frame capture time, also before a first segment
// - last four header bytes give the byte count of the whole frame
// - two bytes per word, earlier byte low, odd frames end with a filler byte
`ifndef VID_FMT4_MAP_VH
`define VID_FMT4_MAP_VH
// ****************************************
// register indices
// ****************************************
`define REG_CTRL     4'h0
`define REG_SEGLEN   4'h1
`define REG_FPP      4'h2
`define REG_STATUS   4'h3
// ****************************************
// control fields and reset values
// ****************************************
`define CTRL_EN      0
`define CTRL_MODE_LO 1
`define CTRL_HDR     3
`define CTRL_ABS     4
`define CTRL_FMT_LO  5
`define CTRL_RST     7'h00
`define SEGLEN_RST   32'h00000400
`define FPP_RST      8'h02
`define MODE_ONE     2'h0
`define MODE_MULTI   2'h1
`define MODE_SEG     2'h2
// ****************************************
// channel-specific word layout
// ****************************************
`define CSW_PART_LO  30
`define CSW_SUM_LO   28
`define CSW_HDR      27
`define CSW_RSV_W    27
`define PART_MID     2'h0
`define PART_FIRST   2'h1
`define PART_LAST    2'h2
`define SUM_SEG      2'h0
`define SUM_ONE      2'h1
`define SUM_MULTI    2'h2
`define FILL_BYTE    8'h00
`define HDR_WORDS    4'h6
`define CSW_WORDS    4'h2
`define ALL_WORDS    4'h8
`endif

//--- hdl/vid_fmt4_framer.v
// format 4 compressed video packet body formatter
//
// The address map and the strobed register port were left to the implementer.
`timescale 1ns/1ns
`default_nettype none
`include "vid_fmt4_map.vh"
module vid_fmt4_framer
#(
  parameter FCNT_W = 8
)
(
  input  wire              sys_clk,
  input  wire              rst_n,
  input  wire              clk_en,
  input  wire [3:0]        reg_addr,
  input  wire [31:0]       reg_wdata,
  input  wire              reg_wr,
  input  wire              reg_rd,
  output reg  [31:0]       reg_rdata,
  input  wire              src_valid,
  input  wire              src_first,
  input  wire [7:0]        src_byte,
  input  wire [31:0]       src_len,
  output reg               src_ready,
  input  wire [47:0]       rtc_time,
  input  wire [63:0]       abs_time,
  output reg  [1:0]        time_fmt,
  input  wire              out_ready,
  output reg               out_valid,
  output reg  [15:0]       out_data,
  output reg               out_sop,
  output reg               out_eop
);

  // ****************************************
  // states and storage
  // ****************************************
  localparam S_IDLE = 2'h0;
  localparam S_HEAD = 2'h1;
  localparam S_DATA = 2'h2;

  reg  [1:0]        st_q;
  reg  [1:0]        st_d;
  reg  [3:0]        cnt_q;
  reg  [3:0]        cnt_d;
  reg  [127:0]      sh_q;
  reg  [127:0]      sh_d;
  reg  [7:0]        lo_q;
  reg  [7:0]        lo_d;
  reg               have_q;
  reg               have_d;
  reg               pend_q;
  reg               pend_d;
  reg  [15:0]       pw_q;
  reg  [15:0]       pw_d;
  reg               peop_q;
  reg               peop_d;
  reg  [31:0]       rem_q;
  reg  [31:0]       rem_d;
  reg  [31:0]       srem_q;
  reg  [31:0]       srem_d;
  reg  [FCNT_W-1:0] fcnt_q;
  reg  [FCNT_W-1:0] fcnt_d;
  reg               sopf_q;
  reg               sopf_d;
  reg  [1:0]        pm_q;
  reg  [1:0]        pm_d;
  reg               ph_q;
  reg               ph_d;
  reg  [15:0]       npkt_q;
  reg  [15:0]       npkt_d;
  reg  [6:0]        ctrl_q;
  reg  [31:0]       seglen_q;
  reg  [FCNT_W-1:0] fpp_q;
  reg               ov_d;
  reg  [15:0]       od_d;
  reg               osop_d;
  reg               oeop_d;
  reg               rdy_d;
  reg  [1:0]        part;
  reg  [1:0]        sum;
  reg               brk_d;

  wire              newp  = (fcnt_q == {FCNT_W{1'b0}});
  wire [1:0]        m_cur = (st_q == S_IDLE && newp) ? ctrl_q[`CTRL_MODE_LO+1:`CTRL_MODE_LO]
                                                     : pm_q;
  wire              h_cur = (st_q == S_IDLE && newp) ? ctrl_q[`CTRL_HDR] : ph_q;
  wire [FCNT_W-1:0] one_f = {{(FCNT_W-1){1'b0}}, 1'b1};
  wire [FCNT_W-1:0] fcnt_n = (st_q == S_IDLE) ? fcnt_q + one_f : fcnt_q;
  // odd segment lengths would split a byte pair, so bit 0 is ignored
  wire [31:0]       sl    = {seglen_q[31:1], 1'b0};
  wire              fin   = (m_cur != `MODE_MULTI) || (fcnt_n >= fpp_q);
  wire              free  = ~out_valid | out_ready;
  wire              acc   = src_valid & src_ready;
  wire              split = (m_cur == `MODE_SEG) && (src_len > sl);
  wire              absm  = ctrl_q[`CTRL_ABS];
  // time is caught with the first byte, i.e. at the frame's first data bit
  wire [31:0]       tlo   = absm ? abs_time[31:0] : rtc_time[31:0];
  wire [31:0]       thi   = absm ? abs_time[63:32]
                                 : {16'h0000, rtc_time[47:32]};
  wire [31:0]       csw   = {part, sum, h_cur, {`CSW_RSV_W{1'b0}}};

  // ****************************************
  // channel-specific word fields
  // ****************************************
  always @*
  begin
    part = `PART_MID;
    sum  = `SUM_ONE;
    if (st_q == S_DATA)
    begin
      part = (rem_q <= sl) ? `PART_LAST : `PART_MID;
      sum  = `SUM_SEG;
    end
    else if (split)
    begin
      part = `PART_FIRST;
      sum  = `SUM_SEG;
    end
    else if (m_cur == `MODE_MULTI && fpp_q > one_f)
      sum = `SUM_MULTI;
  end

  // ****************************************
  // formatter next state
  // ****************************************
  always @*
  begin
    st_d   = st_q;
    cnt_d  = cnt_q;
    sh_d   = sh_q;
    lo_d   = lo_q;
    have_d = have_q;
    pend_d = pend_q;
    pw_d   = pw_q;
    peop_d = peop_q;
    rem_d  = rem_q;
    srem_d = srem_q;
    fcnt_d = fcnt_q;
    sopf_d = sopf_q;
    pm_d   = pm_q;
    ph_d   = ph_q;
    npkt_d = npkt_q;
    ov_d   = out_valid & ~out_ready;
    od_d   = out_data;
    osop_d = out_sop;
    oeop_d = out_eop;
    case (st_q)
      // a stray byte not flagged as first is out of step and dropped
      S_IDLE:
        if (acc & src_first)
        begin
          rem_d  = src_len - 32'h1;
          srem_d = sl - 32'h1;
          fcnt_d = fcnt_n;
          lo_d   = src_byte;
          have_d = 1'b1;
          if (src_len == 32'h1)
          begin
            pw_d   = {`FILL_BYTE, src_byte};
            pend_d = 1'b1;
            have_d = 1'b0;
            peop_d = fin;
          end
          if (newp)
          begin
            pm_d   = m_cur;
            ph_d   = h_cur;
            sh_d   = {src_len, thi, tlo, csw};
            cnt_d  = h_cur ? `ALL_WORDS : `CSW_WORDS;
            sopf_d = 1'b1;
            st_d   = S_HEAD;
          end
          else if (h_cur)
          begin
            sh_d  = {32'h0, src_len, thi, tlo};
            cnt_d = `HDR_WORDS;
            st_d  = S_HEAD;
          end
          else
            st_d = S_DATA;
        end
      // header words leave low half first, low long word first
      S_HEAD:
        if (free)
        begin
          ov_d   = 1'b1;
          od_d   = sh_q[15:0];
          osop_d = sopf_q;
          oeop_d = 1'b0;
          sopf_d = 1'b0;
          sh_d   = {16'h0, sh_q[127:16]};
          cnt_d  = cnt_q - 4'h1;
          if (cnt_q == 4'h1)
            st_d = S_DATA;
        end
      S_DATA:
      begin
        if (pend_q & free)
        begin
          ov_d   = 1'b1;
          od_d   = pw_q;
          osop_d = 1'b0;
          oeop_d = peop_q;
          pend_d = 1'b0;
          if (peop_q)
            npkt_d = npkt_q + 16'h1;
        end
        // ready is only high with no word pending, so no clash above
        if (acc)
        begin
          rem_d  = rem_q - 32'h1;
          srem_d = srem_q - 32'h1;
          lo_d   = src_byte;
          have_d = ~have_q;
          if (have_q || rem_q == 32'h1)
          begin
            pw_d   = have_q ? {src_byte, lo_q} : {`FILL_BYTE, src_byte};
            pend_d = 1'b1;
            have_d = 1'b0;
            peop_d = (rem_q == 32'h1) ? fin : (pm_q == `MODE_SEG && srem_q == 32'h1);
          end
        end
        // boundary only once the closing word has left the pair stage
        if (!pend_q && !have_q && (rem_q == 32'h0 || (pm_q == `MODE_SEG && srem_q == 32'h0)))
        begin
          if (rem_q == 32'h0)
          begin
            st_d = S_IDLE;
            if (fin)
              fcnt_d = {FCNT_W{1'b0}};
          end
          else
          begin
            sh_d   = {96'h0, csw};
            cnt_d  = `CSW_WORDS;
            sopf_d = 1'b1;
            srem_d = sl;
            st_d   = S_HEAD;
          end
        end
      end
      default:
        st_d = S_IDLE;
    endcase
    brk_d = (rem_d == 32'h0) || (pm_d == `MODE_SEG && srem_d == 32'h0);
    rdy_d = (st_d == S_IDLE && ctrl_q[`CTRL_EN]) || (st_d == S_DATA && !pend_d && !brk_d);
  end

  // ****************************************
  // formatter registers
  // ****************************************
  always @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      st_q      <= S_IDLE;
      cnt_q     <= 4'h0;
      sh_q      <= 128'h0;
      lo_q      <= 8'h00;
      have_q    <= 1'b0;
      pend_q    <= 1'b0;
      pw_q      <= 16'h0000;
      peop_q    <= 1'b0;
      rem_q     <= 32'h0;
      srem_q    <= 32'h0;
      fcnt_q    <= {FCNT_W{1'b0}};
      sopf_q    <= 1'b0;
      pm_q      <= `MODE_ONE;
      ph_q      <= 1'b0;
      npkt_q    <= 16'h0000;
      out_valid <= 1'b0;
      out_data  <= 16'h0000;
      out_sop   <= 1'b0;
      out_eop   <= 1'b0;
      src_ready <= 1'b0;
    end
    else if (clk_en)
    begin
      st_q      <= st_d;
      cnt_q     <= cnt_d;
      sh_q      <= sh_d;
      lo_q      <= lo_d;
      have_q    <= have_d;
      pend_q    <= pend_d;
      pw_q      <= pw_d;
      peop_q    <= peop_d;
      rem_q     <= rem_d;
      srem_q    <= srem_d;
      fcnt_q    <= fcnt_d;
      sopf_q    <= sopf_d;
      pm_q      <= pm_d;
      ph_q      <= ph_d;
      npkt_q    <= npkt_d;
      out_valid <= ov_d;
      out_data  <= od_d;
      out_sop   <= osop_d;
      out_eop   <= oeop_d;
      src_ready <= rdy_d;
    end
  end

  // ****************************************
  // register port
  // ****************************************
  // mode and header enable are latched per packet, so changes land cleanly
  always @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      ctrl_q    <= `CTRL_RST;
      seglen_q  <= `SEGLEN_RST;
      fpp_q     <= `FPP_RST;
      time_fmt  <= 2'h0;
      reg_rdata <= 32'h0;
    end
    else if (clk_en)
    begin
      time_fmt  <= ctrl_q[`CTRL_FMT_LO+1:`CTRL_FMT_LO];
      reg_rdata <= 32'h0;
      if (reg_wr)
      begin
        case (reg_addr)
          `REG_CTRL:   ctrl_q   <= reg_wdata[6:0];
          `REG_SEGLEN: seglen_q <= reg_wdata;
          `REG_FPP:    fpp_q    <= reg_wdata[FCNT_W-1:0];
          default:     ;
        endcase
      end
      if (reg_rd)
      begin
        case (reg_addr)
          `REG_CTRL:   reg_rdata <= {25'h0, ctrl_q};
          `REG_SEGLEN: reg_rdata <= seglen_q;
          `REG_FPP:    reg_rdata <= {{(32-FCNT_W){1'b0}}, fpp_q};
          `REG_STATUS: reg_rdata <= {npkt_q, 11'h0, pend_q, have_q, src_ready, st_q};
          default:     reg_rdata <= 32'h0;
        endcase
      end
    end
  end

endmodule
`default_nettype wire

//--- testbench/vid_fmt4_framer_properties.sv
// assertion checker for the video packet body formatter
`timescale 1ns/1ns
`default_nettype none
module vid_fmt4_framer_properties
(
  input wire logic        sys_clk,
  input wire logic        rst_n,
  input wire logic        clk_en,
  input wire logic [3:0]  reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire logic [1:0]  time_fmt,
  input wire logic        out_ready,
  input wire logic        out_valid,
  input wire logic [15:0] out_data,
  input wire logic        out_sop,
  input wire logic        out_eop
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  logic hi_q;
  logic pkt_q;
  // track the word after the opening word and whether a packet is open
  always @(posedge sys_clk)
    if (!rst_n)
    begin
      hi_q <= 1'b0;
      pkt_q <= 1'b0;
    end
    else if (out_valid && out_ready && clk_en)
    begin
      hi_q <= out_sop;
      pkt_q <= !out_eop;
    end
  property p_csw_lo; out_valid && out_sop |-> out_data == 16'h0000; endproperty
  a_csw_lo: assert property (p_csw_lo) else $error("low half of opening word not zero");
  property p_csw_hi;
    out_valid && hi_q |-> out_data[10:0] == 11'h0 && out_data[15:14] != 2'h3
      && out_data[13:12] != 2'h3;
  endproperty
  a_csw_hi: assert property (p_csw_hi) else $error("bad codes in opening word");
  property p_sop_eop; out_valid && out_sop |-> !out_eop; endproperty
  a_sop_eop: assert property (p_sop_eop) else $error("packet ends on opening word");
  property p_start; out_valid && !pkt_q |-> out_sop; endproperty
  a_start: assert property (p_start) else $error("packet lacks opening word");
  property p_inside; out_valid && pkt_q |-> !out_sop; endproperty
  a_inside: assert property (p_inside) else $error("new packet inside packet");
  property p_hold; out_valid && !out_ready |=> out_valid && $stable(out_data) && $stable(out_eop); endproperty
  a_hold: assert property (p_hold) else $error("word changed while stalled");
  property p_fmt; reg_wr && clk_en && reg_addr == 4'h0 |-> ##2 time_fmt == $past(reg_wdata[6:5], 2); endproperty
  a_fmt: assert property (p_fmt) else $error("time format not exported");
  property p_rdata; clk_en && !reg_rd |=> reg_rdata == 32'h0; endproperty
  a_rdata: assert property (p_rdata) else $error("read data outside its cycle");
endmodule
bind vid_fmt4_framer vid_fmt4_framer_properties u_props (.sys_clk, .rst_n, .clk_en, .reg_addr,
  .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .time_fmt, .out_ready, .out_valid, .out_data, .out_sop,
  .out_eop);
`default_nettype wire

//--- testbench/vid_fmt4_src_model.sv
// frame source and stalling sink facing the formatter
`timescale 1ns/1ns
`default_nettype none
module vid_fmt4_src_model
(
  input  wire logic        sys_clk,
  input  wire logic        go,
  input  wire logic [31:0] len,
  input  wire logic [7:0]  base,
  input  wire logic        src_ready,
  output var  logic        src_valid = 1'b0,
  output var  logic        src_first = 1'b0,
  output var  logic [7:0]  src_byte = 8'h00,
  output var  logic [31:0] src_len = 32'h1,
  output var  logic        out_ready = 1'b0,
  output var  logic        busy = 1'b0
);
  logic [31:0] left = 32'h0;
  logic [7:0]  lfsr = 8'h5a;
  // bytes held until taken; idle line inverted so stale data never matches
  always @(posedge sys_clk)
  begin
    lfsr <= {lfsr[6:0], lfsr[7] ^ lfsr[5] ^ lfsr[4] ^ lfsr[3]};
    out_ready <= lfsr[0] | lfsr[1]; // sink stalls about a quarter of cycles
    if (go && !busy)
    begin
      {busy, src_valid, src_first} <= 3'h7;
      src_byte <= base;
      src_len <= len;
      left <= len;
    end
    else if (src_valid && src_ready)
    begin
      src_first <= 1'b0;
      left <= left - 32'h1;
      src_byte <= left == 32'h1 ? ~src_byte : src_byte + 8'h1;
      if (left == 32'h1)
        {busy, src_valid} <= 2'h0;
    end
  end
endmodule
`default_nettype wire

//--- testbench/vid_fmt4_framer_tb_top.sv
// self-checking bench for the video packet body formatter
`timescale 1ns/1ns
`default_nettype none
`include "vid_fmt4_map.vh"
module vid_fmt4_framer_tb_top;
  logic        sys_clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        clk_en = 1'b1;
  logic [3:0]  reg_addr = 4'h0;
  logic [31:0] reg_wdata = 32'h0;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic [47:0] rtc_time = 48'h0;
  logic [63:0] abs_time = 64'h0;
  logic        go = 1'b0;
  logic [31:0] len = 32'h1;
  logic [7:0]  base = 8'h0;
  wire  [31:0] reg_rdata;
  wire  [31:0] src_len;
  wire  [7:0]  src_byte;
  wire  [15:0] out_data;
  wire  [1:0]  time_fmt;
  wire         src_valid, src_first, src_ready, out_ready, out_valid, out_sop, out_eop, busy;
  logic [17:0] exp_q[$];
  logic [17:0] got_q[$];
  logic [63:0] rng = 64'd72;
  int          err_total = 0;
  int          checked = 0;
  int          cyc = 0;
  vid_fmt4_framer dut (.sys_clk, .rst_n, .clk_en, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .src_valid, .src_first, .src_byte, .src_len, .src_ready, .rtc_time, .abs_time,
    .time_fmt, .out_ready, .out_valid, .out_data, .out_sop, .out_eop);
  vid_fmt4_src_model u_src (.sys_clk, .go, .len, .base, .src_ready, .src_valid, .src_first,
    .src_byte, .src_len, .out_ready, .busy);
  always #5 sys_clk = ~sys_clk;
  // collect accepted words; a hang is cut short after 30000 cycles
  always @(posedge sys_clk)
  begin
    if (clk_en && out_valid && out_ready)
      got_q.push_back({out_sop, out_eop, out_data});
    cyc++;
    if (cyc == 30000)
    begin
      err_total++;
      final_report;
    end
  end
  function logic [31:0] rnd();
    rng = rng ^ (rng << 13);
    rng = rng ^ (rng >> 7);
    rng = rng ^ (rng << 17);
    return rng[31:0];
  endfunction
  task chk(string what, logic [31:0] e, logic [31:0] g);
    checked++;
    if (g !== e)
    begin
      err_total++;
      $display("mismatch %s expected %h seen %h", what, e, g);
    end
  endtask
  // expected words: opening word, header, byte pairs with filler
  task put(logic [15:0] w, logic s = 1'b0, logic e = 1'b0);
    exp_q.push_back({s, e, w});
  endtask
  task csw(logic [3:0] ps, logic h);
    put(16'h0, 1'b1);
    put({ps, h, 11'h0});
  endtask
  task hdr(logic [63:0] t, logic [31:0] n);
    for (int i = 0; i < 4; i++)
      put(t[16*i+:16]);
    put(n[15:0]);
    put(n[31:16]);
  endtask
  task dat(logic [7:0] b, int n, logic e);
    for (int k = 0; k < n; k += 2)
      put({k + 1 < n ? b + 8'(k + 1) : `FILL_BYTE, b + 8'(k)}, 1'b0, e && k + 2 >= n);
  endtask
  task wr(logic [3:0] a, logic [31:0] d);
    @(posedge sys_clk);
    {reg_wr, reg_addr, reg_wdata} <= {1'b1, a, d};
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask
  task rd(logic [3:0] a, logic [31:0] e);
    @(posedge sys_clk);
    {reg_rd, reg_addr} <= {1'b1, a};
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    @(negedge sys_clk);
    chk("register", e, reg_rdata);
  endtask
  task frame(int n, logic [7:0] b, logic [63:0] t);
    @(posedge sys_clk);
    {go, len, base, rtc_time, abs_time} <= {1'b1, 32'(n), b, t[47:0], t};
    @(posedge sys_clk);
    go <= 1'b0;
    @(negedge sys_clk);
    for (int i = 0; i < 2000 && busy; i++)
      @(negedge sys_clk);
    chk("source drained", 32'h0, busy);
  endtask
  task done(string name);
    for (int i = 0; i < 999 && got_q.size() < exp_q.size(); i++)
      @(negedge sys_clk);
    chk("word count", exp_q.size(), got_q.size());
    foreach (exp_q[i])
      if (i < got_q.size())
        chk("word", exp_q[i], got_q[i]);
    exp_q.delete();
    got_q.delete();
    $display("test %s done", name);
  endtask
  task final_report;
    $display("comparisons %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // main sequence: registers, single frames, several frames, segments
  initial
  begin
    logic [63:0] t;
    logic [7:0]  b;
    logic [1:0]  f;
    int          n;
    repeat (12) @(posedge sys_clk);
    rst_n <= 1'b1;
    rd(4'h1, `SEGLEN_RST);
    rd(4'h2, 32'(`FPP_RST));
    rd(4'h0, 32'h0);
    rd(4'h3, 32'h0);
    wr(4'hc, 32'hffffffff);
    rd(4'hc, 32'h0);
    // a frozen port must ignore the write
    @(posedge sys_clk);
    clk_en <= 1'b0;
    wr(4'h1, 32'h8);
    clk_en <= 1'b1;
    rd(4'h1, `SEGLEN_RST);
    done("registers");
    for (int m = 0; m < 3; m++)
    begin
      f = 2'(rnd());
      wr(4'h0, {25'h0, f, m == 2, m > 0, 3'h1});
      for (int i = 0; i < 3; i++)
      begin
        n = i == 0 ? 1 : int'(rnd() % 40) + 1;
        t = {rnd(), rnd()};
        b = 8'(rnd());
        csw(4'h1, m > 0);
        if (m > 0)
          hdr(m == 2 ? t : {16'h0, t[47:0]}, n);
        dat(b, n, 1'b1);
        frame(n, b, t);
      end
      chk("time format", f, time_fmt);
      done("single frame");
    end
    wr(4'h2, 32'h3);
    // several frames with and then without per-frame headers
    for (int h = 1; h >= 0; h--)
    begin
      wr(4'h0, {28'h0, h[0], 3'h3});
      csw(4'h2, h[0]);
      for (int i = 0; i < 3; i++)
      begin
        n = int'(rnd() % 9) + 1;
        t = {rnd(), rnd()};
        if (h != 0)
          hdr({16'h0, t[47:0]}, n);
        dat(8'(i * 64), n, i == 2);
        frame(n, 8'(i * 64), t);
      end
      done("several frames");
    end
    wr(4'h1, 32'h4);
    wr(4'h0, 32'hd);
    t = {rnd(), rnd()};
    csw(4'h4, 1'b1);
    hdr({16'h0, t[47:0]}, 9);
    dat(8'h10, 4, 1'b1);
    csw(4'h0, 1'b1);
    dat(8'h14, 4, 1'b1);
    csw(4'h8, 1'b1);
    dat(8'h18, 1, 1'b1);
    frame(9, 8'h10, t);
    csw(4'h1, 1'b1);
    hdr({16'h0, t[47:0]}, 4);
    dat(8'h20, 4, 1'b1);
    frame(4, 8'h20, t);
    done("segments");
    // fifteen packets closed, idle with the source side ready
    rd(4'h3, 32'h000f0004);
    final_report;
  end
endmodule
`default_nettype wire
